/* sdd_pkg.sv */
// Purpose: Shared constants for the sigma-delta decimation and sync block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Coefficients are signed Q3.20, samples are signed DATA_W words
package sdd_pkg;
  // ---------------------------------------------------------------
  // Data path widths and array shape
  // ---------------------------------------------------------------
  localparam int MOD_W = 4;
  localparam int DATA_W = 24;
  localparam int COEF_W = 24;
  localparam int COEF_FRAC = 20;
  localparam int ACC_W = 48;
  localparam int MAC_BLOCKS = 36;
  localparam int TAPS_PER_BLOCK = 3;
  localparam int TAP_COUNT = 108;
  localparam int PRESET_STAGES = 3;
  localparam int SEQ_W = 3;
  localparam int RATE_W = 9;
  localparam int CFG_ADDR_W = 7;
  localparam int CFG_DATA_W = 24;
  // ---------------------------------------------------------------
  // Configuration load map
  // ---------------------------------------------------------------
  localparam logic [CFG_ADDR_W-1:0] ADDR_RATE = 7'h6c;
  localparam logic [CFG_ADDR_W-1:0] ADDR_FEEDBACK = 7'h6d;
  localparam int RATE_DECIM_LSB = 0;
  localparam int RATE_INTERP_LSB = 9;
  localparam logic [RATE_W-1:0] DECIM_RESET = 9'h002;
  localparam logic [RATE_W-1:0] INTERP_RESET = 9'h001;
  localparam logic [RATE_W-1:0] DECIM_MIN = 9'h002;
  localparam logic [RATE_W-1:0] RATE_MAX = 9'h100;
  localparam logic [COEF_W-1:0] COEF_RESET = 24'h000000;
  localparam logic [SEQ_W-1:0] SEQ_ZERO = 3'h0;
endpackage

/* sdd_mac_if.sv */
// Purpose: Carrier between the postprocessor array and one MAC block
// Assumes: All signals on the common clock
// Notes: One instance per MAC block
`timescale 1ns/100ps
`default_nettype none
interface sdd_mac_if;
  import sdd_pkg::*;
  logic en;
  logic signed [DATA_W-1:0] x;
  logic signed [ACC_W-1:0] sum_in;
  logic signed [ACC_W-1:0] sum_out;
  logic cfg_we;
  logic [1:0] cfg_tap;
  logic signed [COEF_W-1:0] cfg_coef;
  modport array (output en, x, sum_in, cfg_we, cfg_tap, cfg_coef, input sum_out);
  modport block (input en, x, sum_in, cfg_we, cfg_tap, cfg_coef, output sum_out);
endinterface
`default_nettype wire

/* sdd_mac_block.sv */
// Purpose: One systolic MAC block, three taps in transposed form
// Assumes: en pulses once per postprocessor input word
// Notes: Coefficients change only through the load port
`timescale 1ns/100ps
`default_nettype none
module sdd_mac_block
  import sdd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Array side
  sdd_mac_if.block mb
);
  logic signed [COEF_W-1:0] coef_ff [TAPS_PER_BLOCK];
  logic signed [ACC_W-1:0] r1_ff, r2_ff, sum_ff;
  logic signed [ACC_W-1:0] prod [TAPS_PER_BLOCK];

  // ---------------------------------------------------------------
  // Three multipliers, products summed into the carried partial sum
  // ---------------------------------------------------------------
  for (genvar t = 0; t < TAPS_PER_BLOCK; t++) begin : g_mul
    assign prod[t] = mb.x * coef_ff[t];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r1_ff <= '0;
      r2_ff <= '0;
      sum_ff <= '0;
    end else if (mb.en) begin
      sum_ff <= prod[0] + r1_ff;
      r1_ff <= prod[1] + r2_ff;
      r2_ff <= prod[2] + mb.sum_in;
    end
  end

  always_ff @(posedge clk) begin
    for (int t = 0; t < TAPS_PER_BLOCK; t++) begin
      if (!reset_n) begin
        coef_ff[t] <= COEF_RESET;
      end else if (mb.cfg_we && mb.cfg_tap == 2'(t)) begin
        coef_ff[t] <= mb.cfg_coef;
      end
    end
  end

  assign mb.sum_out = sum_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  mac_hold_a: assert property (!mb.en |=> $stable(sum_ff))
    else $error("MAC sum moved without enable");
  coef_load_a: assert property (mb.cfg_we && mb.cfg_tap == 2'h0 |=>
      coef_ff[0] == $past(mb.cfg_coef))
    else $error("Coefficient load lost");
endmodule
`default_nettype wire

/* sdd_top.sv */
// Purpose: Preset decimator, systolic postprocessor and sync sequencer
// Assumes: clk is the master clock, 25 MHz, never stopped
// Notes: Pins pass two flops; multiple devices align on a shared sync
`timescale 1ns/100ps
`default_nettype none
module sdd_top
  import sdd_pkg::*;
#(
  parameter int MW = MOD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pins from the system controller
  input wire logic oscillator_disable_strap,
  input wire logic sync_pin,
  input wire logic init_pin,
  // Modulator word, same clock
  input wire logic signed [MW-1:0] mod_word,
  // Configuration load port
  input wire logic cfg_we,
  input wire logic [CFG_ADDR_W-1:0] cfg_addr,
  input wire logic [CFG_DATA_W-1:0] cfg_data,
  // Clock source control
  output logic osc_enable,
  output logic ext_clk_select,
  // Results and status
  output logic signed [DATA_W-1:0] result,
  output logic result_valid,
  output logic [SEQ_W-1:0] seq_count,
  output logic cfg_reject
);
  // Left-justifying needs at least one padding bit below the word
  if (MW < 1 || MW >= DATA_W) begin : g_chk_mw
    $error("MW out of range");
  end
  if (MAC_BLOCKS * TAPS_PER_BLOCK != TAP_COUNT || SEQ_W != PRESET_STAGES) begin : g_chk_shape
    $error("Array shape inconsistent");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic strap_s1_ff, strap_s2_ff, sync_s1_ff, sync_s2_ff, init_s1_ff, init_s2_ff;
  logic osc_enable_ff, ext_clk_select_ff;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {strap_s1_ff, strap_s2_ff} <= 2'h0;
      {sync_s1_ff, sync_s2_ff} <= 2'h0;
      {init_s1_ff, init_s2_ff} <= 2'h0;
    end else begin
      strap_s1_ff <= oscillator_disable_strap;
      strap_s2_ff <= strap_s1_ff;
      sync_s1_ff <= sync_pin;
      sync_s2_ff <= sync_s1_ff;
      init_s1_ff <= init_pin;
      init_s2_ff <= init_s1_ff;
    end
  end

  // Gating stays on after reset so the master clock is never stopped
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      osc_enable_ff <= 1'b1;
      ext_clk_select_ff <= 1'b0;
    end else begin
      osc_enable_ff <= !strap_s2_ff;
      ext_clk_select_ff <= strap_s2_ff;
    end
  end

  wire sync_act = sync_s2_ff || init_s2_ff;

  // ---------------------------------------------------------------
  // Filter sequencer
  // ---------------------------------------------------------------
  logic [SEQ_W-1:0] seq_ff;
  wire [SEQ_W-1:0] nxt_seq = sync_act ? SEQ_ZERO : seq_ff + 3'h1;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seq_ff <= SEQ_ZERO;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // ---------------------------------------------------------------
  // Preset filter: three [1 2 1]/4 half-band stages
  // ---------------------------------------------------------------
  logic signed [DATA_W-1:0] stg_d [PRESET_STAGES+1];
  logic stg_v [PRESET_STAGES+1];
  assign stg_d[0] = {mod_word, {(DATA_W-MW){1'b0}}};
  assign stg_v[0] = 1'b1;

  for (genvar k = 0; k < PRESET_STAGES; k++) begin : g_stage
    logic signed [DATA_W-1:0] x1_ff, x2_ff, y_ff;
    logic v_ff;
    logic signed [DATA_W+1:0] hb;
    // Emitting on seq bit k halves the rate at each stage
    wire emit = stg_v[k] && seq_ff[k];
    assign hb = stg_d[k] + (x1_ff <<< 1) + x2_ff;
    always_ff @(posedge clk) begin
      if (!reset_n || sync_act) begin
        {x1_ff, x2_ff, y_ff} <= '0;
        v_ff <= 1'b0;
      end else begin
        v_ff <= emit;
        if (stg_v[k]) begin
          x1_ff <= stg_d[k];
          x2_ff <= x1_ff;
        end
        if (emit) begin
          y_ff <= hb[DATA_W+1:2];
        end
      end
    end
    assign stg_d[k+1] = y_ff;
    assign stg_v[k+1] = v_ff;
  end

  wire post_en = stg_v[PRESET_STAGES];

  // ---------------------------------------------------------------
  // Configuration load decode
  // ---------------------------------------------------------------
  logic [RATE_W-1:0] decim_ff, interp_ff;
  logic signed [COEF_W-1:0] fb_coef_ff;
  logic cfg_reject_ff;
  wire is_coef = cfg_addr < CFG_ADDR_W'(TAP_COUNT);
  wire [CFG_ADDR_W-1:0] cfg_blk = cfg_addr / CFG_ADDR_W'(TAPS_PER_BLOCK);
  wire [CFG_ADDR_W-1:0] cfg_tap = cfg_addr - cfg_blk * CFG_ADDR_W'(TAPS_PER_BLOCK);
  wire [RATE_W-1:0] new_decim = cfg_data[RATE_DECIM_LSB +: RATE_W];
  wire [RATE_W-1:0] new_interp = cfg_data[RATE_INTERP_LSB +: RATE_W];
  // Interp/decim at or below one half keeps output within clock/16
  wire rate_ok = new_decim >= DECIM_MIN && new_decim <= RATE_MAX &&
                 new_interp != 9'h000 && {new_interp, 1'b0} <= {1'b0, new_decim};
  wire rate_we = cfg_we && cfg_addr == ADDR_RATE;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      decim_ff <= DECIM_RESET;
      interp_ff <= INTERP_RESET;
      fb_coef_ff <= COEF_RESET;
      cfg_reject_ff <= 1'b0;
    end else begin
      if (rate_we) begin
        cfg_reject_ff <= !rate_ok;
      end
      if (rate_we && rate_ok) begin
        decim_ff <= new_decim;
        interp_ff <= new_interp;
      end
      if (cfg_we && cfg_addr == ADDR_FEEDBACK) begin
        fb_coef_ff <= cfg_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Postprocessor array
  // ---------------------------------------------------------------
  logic signed [ACC_W-1:0] sum_chain [MAC_BLOCKS+1];
  logic signed [DATA_W-1:0] arr_y, filt_in;
  logic signed [ACC_W-1:0] fb_prod;
  assign sum_chain[MAC_BLOCKS] = '0;
  assign arr_y = sum_chain[0][COEF_FRAC +: DATA_W];
  assign fb_prod = fb_coef_ff * arr_y;
  // Recursive path: zero feedback coefficient gives a pure FIR
  assign filt_in = stg_d[PRESET_STAGES] + fb_prod[COEF_FRAC +: DATA_W];

  sdd_mac_if mb [MAC_BLOCKS] ();
  for (genvar b = 0; b < MAC_BLOCKS; b++) begin : g_mac
    assign mb[b].en = post_en;
    assign mb[b].x = filt_in;
    assign mb[b].sum_in = sum_chain[b+1];
    assign sum_chain[b] = mb[b].sum_out;
    assign mb[b].cfg_we = cfg_we && is_coef && cfg_blk == CFG_ADDR_W'(b);
    assign mb[b].cfg_tap = cfg_tap[1:0];
    assign mb[b].cfg_coef = cfg_data;
    sdd_mac_block sdd_mac_block_inst (
      .clk(clk),
      .reset_n(reset_n),
      .mb(mb[b])
    );
  end

  // ---------------------------------------------------------------
  // Rate changer and output register
  // ---------------------------------------------------------------
  logic post_done_ff, result_valid_ff;
  logic [RATE_W-1:0] phase_ff;
  logic signed [DATA_W-1:0] result_ff;
  wire [RATE_W:0] phase_sum = {1'b0, phase_ff} + {1'b0, interp_ff};
  wire out_slot = post_done_ff && phase_sum >= {1'b0, decim_ff};
  wire [RATE_W:0] phase_wrap = phase_sum - {1'b0, decim_ff};
  wire [RATE_W-1:0] nxt_phase = out_slot ? phase_wrap[RATE_W-1:0] : phase_sum[RATE_W-1:0];
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      post_done_ff <= 1'b0;
      phase_ff <= '0;
      result_ff <= '0;
      result_valid_ff <= 1'b0;
    end else begin
      post_done_ff <= post_en && !sync_act;
      result_valid_ff <= out_slot;
      if (sync_act) begin
        phase_ff <= '0;
      end else if (rate_we && rate_ok) begin
        // Old phase may exceed the new ratio and burst outputs
        phase_ff <= '0;
      end else if (post_done_ff) begin
        phase_ff <= nxt_phase;
      end
      if (out_slot) begin
        result_ff <= arr_y;
      end
    end
  end

  assign osc_enable = osc_enable_ff;
  assign ext_clk_select = ext_clk_select_ff;
  assign result = result_ff;
  assign result_valid = result_valid_ff;
  assign seq_count = seq_ff;
  assign cfg_reject = cfg_reject_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [4:0] gap_ff;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gap_ff <= 5'h1f;
    end else if (result_valid_ff) begin
      gap_ff <= 5'h01;
    end else if (gap_ff != 5'h1f) begin
      gap_ff <= gap_ff + 5'h01;
    end
  end

  sequence s_sync_release;
    sync_act ##1 !sync_act;
  endsequence

  osc_on_a: assert property (!strap_s2_ff |=> osc_enable_ff && !ext_clk_select_ff)
    else $error("Oscillator not enabled with strap low");
  ext_clk_a: assert property (strap_s2_ff |=> ext_clk_select_ff && !osc_enable_ff)
    else $error("External clock not selected with strap high");
  seq_hold_a: assert property (sync_act |=> seq_ff == SEQ_ZERO)
    else $error("Sequencer not held during sync");
  seq_resume_a: assert property (s_sync_release |=> seq_ff == 3'h1 ##1 seq_ff == 3'h2)
    else $error("Sequencer did not resume from zero");
  init_sync_a: assert property (init_s2_ff |-> ##1 seq_ff == SEQ_ZERO)
    else $error("Init did not force sync");
  preset_rate_a: assert property (post_en |-> seq_ff == SEQ_ZERO ##1 !post_en[*7])
    else $error("Preset output not at clock/8");
  out_spacing_a: assert property (result_valid_ff |-> gap_ff >= 5'h10)
    else $error("Output faster than clock/16");
  out_load_a: assert property (out_slot |=> result_valid_ff && result_ff == $past(arr_y))
    else $error("Output register missed its slot");
  rate_range_a: assert property (decim_ff >= DECIM_MIN && decim_ff <= RATE_MAX &&
      {interp_ff, 1'b0} <= {1'b0, decim_ff})
    else $error("Rate setting out of range");
  sync_align_a: assert property (s_sync_release |-> phase_ff == '0)
    else $error("Rate phase not cleared by sync");
endmodule
`default_nettype wire

/* sdd_ctrl_model.sv */
// Purpose: System controller model driving strap, sync, init and modulator words
// Assumes: Master clock made by the bench, shared with the block
// Notes: Pins change 1 ns after a rising edge, never on the edge itself
`timescale 1ns/100ps
`default_nettype none
module sdd_ctrl_model
  import sdd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Pins to the block
  output logic oscillator_disable_strap,
  output logic sync_pin,
  output logic init_pin,
  output logic signed [MOD_W-1:0] mod_word
);
  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  initial begin
    oscillator_disable_strap = 1'b0;
    sync_pin = 1'b0;
    init_pin = 1'b0;
    mod_word = 4'sh0;
  end

  task automatic drive_strap(input logic v);
    @(posedge clk);
    #1;
    oscillator_disable_strap = v;
  endtask

  // Length in clock periods; one period is seen high at the next edge
  task automatic pulse(input logic use_init, input int len);
    @(posedge clk);
    #1;
    if (use_init) begin
      init_pin = 1'b1;
    end else begin
      sync_pin = 1'b1;
    end
    repeat (len) @(posedge clk);
    #1;
    sync_pin = 1'b0;
    init_pin = 1'b0;
  endtask

  task automatic set_word(input logic signed [MOD_W-1:0] v);
    @(posedge clk);
    #1;
    mod_word = v;
  endtask
endmodule
`default_nettype wire

/* sigma_delta_decimation_sync_tb_top.sv */
// Purpose: Self-checking bench for the decimation, postprocessor and sync block
// Assumes: Controller model drives the pins; bench drives the load port
// Notes: Timing expectations follow the two-flop pin synchronisers
`timescale 1ns/100ps
`default_nettype none
module sigma_delta_decimation_sync_tb_top;
  import sdd_pkg::*;
  localparam int TIMEOUT = 30000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cfg_we = 1'b0;
  logic [CFG_ADDR_W-1:0] cfg_addr = 7'h00;
  logic [CFG_DATA_W-1:0] cfg_data = 24'h000000;
  wire logic strap;
  wire logic sync_pin;
  wire logic init_pin;
  wire logic signed [MOD_W-1:0] mod_word;
  logic osc_enable;
  logic ext_clk_select;
  logic signed [DATA_W-1:0] result;
  logic result_valid;
  logic [SEQ_W-1:0] seq_count;
  logic cfg_reject;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;

  // ---------------------------------------------------------------
  // Clock, timeout and instances
  // ---------------------------------------------------------------
  always #20 clk = ~clk;

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == TIMEOUT) begin
      errors = errors + 1;
      end_sim();
    end
  end

  sdd_ctrl_model sdd_ctrl_model_inst (.clk(clk), .oscillator_disable_strap(strap),
    .sync_pin(sync_pin), .init_pin(init_pin), .mod_word(mod_word));

  sdd_top sdd_top_inst (.clk(clk), .reset_n(reset_n), .oscillator_disable_strap(strap),
    .sync_pin(sync_pin), .init_pin(init_pin), .mod_word(mod_word), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .osc_enable(osc_enable),
    .ext_clk_select(ext_clk_select), .result(result), .result_valid(result_valid),
    .seq_count(seq_count), .cfg_reject(cfg_reject));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cfg_write(input logic [CFG_ADDR_W-1:0] a, input logic [CFG_DATA_W-1:0] d);
    tick(1);
    cfg_we = 1'b1;
    cfg_addr = a;
    cfg_data = d;
    tick(1);
    cfg_we = 1'b0;
  endtask

  function automatic logic [CFG_DATA_W-1:0] rate(input int d, input int i);
    return (24'(i) << RATE_INTERP_LSB) | (24'(d) << RATE_DECIM_LSB);
  endfunction

  // Output pulse stands one cycle, so every edge is inspected
  task automatic wait_valid(output int t);
    int k;
    for (k = 0; k < 5000; k++) begin
      tick(1);
      if (result_valid === 1'b1) break;
    end
    t = cyc;
    if (k == 5000) check(48'h0, 48'h1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check(osc_enable, 1'b1);
    check(ext_clk_select, 1'b0);
    check(result, 24'h000000);
    check(result_valid, 1'b0);
    check(seq_count, SEQ_ZERO);
    check(cfg_reject, 1'b0);
  endtask

  task automatic t_strap(input logic v);
    sdd_ctrl_model_inst.drive_strap(v);
    tick(2);
    check(ext_clk_select, !v);
    tick(1);
    check(ext_clk_select, v);
    check(osc_enable, !v);
  endtask

  task automatic t_sync(input logic use_init, input int len);
    int k;
    sdd_ctrl_model_inst.pulse(use_init, len);
    if (len == 1) tick(2);
    for (k = 0; k < 3; k++) begin
      check(seq_count, SEQ_ZERO);
      if (len == 1 || k == 2) break;
      tick(1);
    end
    tick(1);
    check(seq_count, 3'h1);
    tick(1);
    check(seq_count, 3'h2);
  endtask

  task automatic t_reject();
    int bad [4][2] = '{'{1, 1}, '{257, 1}, '{4, 0}, '{4, 3}};
    foreach (bad[k]) begin
      cfg_write(ADDR_RATE, rate(bad[k][0], bad[k][1]));
      tick(1);
      check(cfg_reject, 1'b1);
    end
    cfg_write(ADDR_RATE, rate(256, 1));
    tick(1);
    check(cfg_reject, 1'b0);
  endtask

  task automatic t_rates();
    int tab [4][3] = '{'{2, 1, 16}, '{4, 1, 32}, '{6, 3, 16}, '{256, 1, 2048}};
    int t0, t1, t2;
    foreach (tab[k]) begin
      cfg_write(ADDR_RATE, rate(tab[k][0], tab[k][1]));
      wait_valid(t0);
      wait_valid(t1);
      wait_valid(t2);
      check(t2 - t1, tab[k][2]);
    end
    cfg_write(ADDR_RATE, rate(2, 1));
  endtask

  // Half weight on first and last tap, so DC passes through unchanged
  task automatic t_dc();
    int t;
    sdd_ctrl_model_inst.set_word(4'sh3);
    cfg_write(7'h00, 24'h080000);
    cfg_write(7'h6b, 24'h080000);
    cfg_write(7'h6e, 24'h7fffff);
    tick(1200);
    wait_valid(t);
    check(result, 24'h300000);
    tick(1);
    check(result_valid, 1'b0);
    check(result, 24'h300000);
  endtask

  task automatic t_align();
    int s, t, a, b;
    sdd_ctrl_model_inst.pulse(1'b0, 1);
    s = cyc;
    wait_valid(t);
    a = t - s;
    tick(5);
    sdd_ctrl_model_inst.pulse(1'b0, 1);
    s = cyc;
    wait_valid(t);
    b = t - s;
    check(b, a);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_strap(1'b1);
    t_strap(1'b0);
    t_sync(1'b0, 1);
    t_sync(1'b0, 10);
    t_sync(1'b1, 1);
    t_reject();
    t_rates();
    t_dc();
    t_align();
    end_sim();
  end
endmodule
`default_nettype wire
